/* File: verilog/pll_ctrl_pkg.sv */
// Shared constants for the PLL dynamic phase and settings controller
package pll_ctrl_pkg;

    // ========================================================
    // Register map (word offsets on the plain register port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PHASE_CFG = 4'h1;
    localparam logic [3:0] REG_DIVIDERS = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h5;

    // ========================================================
    // Field positions
    localparam int CTRL_REF_SEL_BIT = 0;
    localparam int CTRL_DYN_PHASE_BIT = 1;
    localparam int CTRL_SW_STEP_BIT = 2;
    localparam int CTRL_SW_DIR_BIT = 3;
    localparam int CTRL_SW_SEL_LSB = 4;
    localparam int IRQ_PHASE_BIT = 0;
    localparam int IRQ_CFG_BIT = 1;
    localparam int IRQ_LOCK_BIT = 2;
    localparam int IRQ_W = 3;

    // ========================================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] PHASE_CFG_RST = 16'h0000;
    localparam logic [31:0] DIVIDERS_RST = 32'h0001_0101;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // ========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int LOCK_TIME_US = 50;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

    // Lock tracking states
    typedef enum logic [1:0] {LOCK_STABLE, LOCK_WAIT} lock_state_t;

endpackage

/* File: verilog/pll_dynamic_phase_and_config_control.sv */
// PLL dynamic phase, reference select and settings controller
// Functional notes
// - Phase shift adjusted dynamically; static setting only held in a register
// - Phase change may drop lock; wait
// - Runtime choice between two reference clocks
// - Bus port rewrites PLL settings, dividers
// - Settings rewrite unlocks until lock time
// - Each step toggle shifts one step while dynamic phase is enabled
module pll_dynamic_phase_and_config_control #(
    parameter int LOCK_CYCLES = pll_ctrl_pkg::LOCK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [1:0] phase_output_select_i,
    input wire logic phase_shift_direction_i,
    input wire logic phase_step_toggle_i,
    output logic reference_clock_selector_o,
    output logic [1:0] step_output_o,
    output logic step_advance_o,
    output logic step_pulse_o,
    output logic [31:0] divider_cfg_o,
    output logic lock_valid_o,
    output logic irq_o
);

    logic [7:0] ctrl_r;
    logic [15:0] phase_cfg_r;
    logic [31:0] dividers_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_mask_r;
    logic [2:0] step_sync_r;
    logic [1:0] sel_sync1_r;
    logic [1:0] sel_sync2_r;
    logic dir_sync1_r;
    logic dir_sync2_r;
    logic [1:0] sel_sync3_r;
    logic [1:0] sel_hold_r;
    logic dir_sync3_r;
    logic dir_hold_r;
    logic [31:0] lock_cnt_r;
    pll_ctrl_pkg::lock_state_t lock_state_r;
    logic pin_step;
    logic sw_step;
    logic any_step;
    logic cfg_write;
    logic relock_event;
    logic [1:0] step_sel;
    logic step_dir;
    logic [2:0] irq_set;
    logic read_irq;

    // ========================================================
    // Register writes
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    assign cfg_write = reg_wr_i && hit(reg_addr_i, pll_ctrl_pkg::REG_DIVIDERS);
    assign read_irq = reg_rd_i && hit(reg_addr_i, pll_ctrl_pkg::REG_IRQ_STATUS);

    // Control register; software step bit is self clearing
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctrl_r <= pll_ctrl_pkg::CTRL_RST;
        else if (reg_wr_i && hit(reg_addr_i, pll_ctrl_pkg::REG_CTRL))
            ctrl_r <= reg_wdata_i[7:0];
        else
            ctrl_r[pll_ctrl_pkg::CTRL_SW_STEP_BIT] <= 1'b0;
    end

    // Static phase setting loaded at configuration; only read back, it drives no output
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            phase_cfg_r <= pll_ctrl_pkg::PHASE_CFG_RST;
        else if (reg_wr_i && hit(reg_addr_i, pll_ctrl_pkg::REG_PHASE_CFG))
            phase_cfg_r <= reg_wdata_i[15:0];
    end

    // Divider settings rewritten while running
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            dividers_r <= pll_ctrl_pkg::DIVIDERS_RST;
        else if (cfg_write)
            dividers_r <= reg_wdata_i;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_mask_r <= pll_ctrl_pkg::IRQ_MASK_RST;
        else if (reg_wr_i && hit(reg_addr_i, pll_ctrl_pkg::REG_IRQ_MASK))
            irq_mask_r <= reg_wdata_i[2:0];
    end

    // ========================================================
    // Pin synchronisers; select and direction count once stages two and three agree
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            step_sync_r <= 3'h0;
            sel_sync1_r <= 2'h0;
            sel_sync2_r <= 2'h0;
            sel_sync3_r <= 2'h0;
            sel_hold_r <= 2'h0;
            dir_sync1_r <= 1'b0;
            dir_sync2_r <= 1'b0;
            dir_sync3_r <= 1'b0;
            dir_hold_r <= 1'b0;
        end
        else
        begin
            step_sync_r <= {step_sync_r[1:0], phase_step_toggle_i};
            sel_sync1_r <= phase_output_select_i;
            sel_sync2_r <= sel_sync1_r;
            sel_sync3_r <= sel_sync2_r;
            dir_sync1_r <= phase_shift_direction_i;
            dir_sync2_r <= dir_sync1_r;
            dir_sync3_r <= dir_sync2_r;
            // A select caught mid-change is never taken; it waits one more cycle
            if (sel_sync2_r == sel_sync3_r)
                sel_hold_r <= sel_sync3_r;
            if (dir_sync2_r == dir_sync3_r)
                dir_hold_r <= dir_sync3_r;
        end
    end

    // Both toggle edges are steps; select and direction must be settled by then
    assign pin_step = (step_sync_r[1] != step_sync_r[2]) &&
        ctrl_r[pll_ctrl_pkg::CTRL_DYN_PHASE_BIT];
    assign sw_step = ctrl_r[pll_ctrl_pkg::CTRL_SW_STEP_BIT] &&
        ctrl_r[pll_ctrl_pkg::CTRL_DYN_PHASE_BIT];
    assign any_step = pin_step || sw_step;
    // Pin step wins over software step so user fabric is never overridden
    assign step_sel = pin_step ? sel_hold_r :
        ctrl_r[pll_ctrl_pkg::CTRL_SW_SEL_LSB +: 2];
    assign step_dir = pin_step ? dir_hold_r :
        ctrl_r[pll_ctrl_pkg::CTRL_SW_DIR_BIT];

    // ========================================================
    // One-step pulse to the analog phase shifter
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            step_pulse_o <= 1'b0;
            step_output_o <= 2'h0;
            step_advance_o <= 1'b0;
        end
        else
        begin
            step_pulse_o <= any_step;
            if (any_step)
            begin
                step_output_o <= step_sel;
                step_advance_o <= step_dir;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reference_clock_selector_o <= 1'b0;
            divider_cfg_o <= pll_ctrl_pkg::DIVIDERS_RST;
        end
        else
        begin
            reference_clock_selector_o <= ctrl_r[pll_ctrl_pkg::CTRL_REF_SEL_BIT];
            divider_cfg_o <= dividers_r;
        end
    end

    // ========================================================
    // Lock tracking: any phase step or settings rewrite restarts the full lock wait
    // Conservative: every step counts, since the feedback output is not known here
    assign relock_event = any_step || cfg_write;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lock_state_r <= pll_ctrl_pkg::LOCK_WAIT;
            lock_cnt_r <= 32'h0;
        end
        else if (relock_event)
        begin
            lock_state_r <= pll_ctrl_pkg::LOCK_WAIT;
            lock_cnt_r <= 32'h0;
        end
        else
        begin
            unique case (lock_state_r)
                pll_ctrl_pkg::LOCK_WAIT:
                begin
                    if (lock_cnt_r >= 32'(LOCK_CYCLES - 1))
                        lock_state_r <= pll_ctrl_pkg::LOCK_STABLE;
                    else
                        lock_cnt_r <= lock_cnt_r + 32'h1;
                end
                pll_ctrl_pkg::LOCK_STABLE:
                    lock_cnt_r <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            lock_valid_o <= 1'b0;
        else
            lock_valid_o <= (lock_state_r == pll_ctrl_pkg::LOCK_STABLE) && !relock_event;
    end

    // ========================================================
    // Sticky events; read clears, a set in the same cycle wins
    assign irq_set = {
        (lock_state_r == pll_ctrl_pkg::LOCK_WAIT) && !relock_event &&
            (lock_cnt_r >= 32'(LOCK_CYCLES - 1)),
        cfg_write,
        any_step};

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_status_r <= 3'h0;
        else
            irq_status_r <= (read_irq ? 3'h0 : irq_status_r) | irq_set;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(((read_irq ? 3'h0 : irq_status_r) | irq_set) & irq_mask_r);
    end

    // ========================================================
    // Read data valid the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 32'h0;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                pll_ctrl_pkg::REG_CTRL: reg_rdata_o <= {24'h0, ctrl_r};
                pll_ctrl_pkg::REG_PHASE_CFG: reg_rdata_o <= {16'h0, phase_cfg_r};
                pll_ctrl_pkg::REG_DIVIDERS: reg_rdata_o <= dividers_r;
                pll_ctrl_pkg::REG_STATUS: reg_rdata_o <= {29'h0, step_advance_o,
                    lock_state_r == pll_ctrl_pkg::LOCK_STABLE, ctrl_r[0]};
                pll_ctrl_pkg::REG_IRQ_STATUS: reg_rdata_o <= {29'h0, irq_status_r};
                pll_ctrl_pkg::REG_IRQ_MASK: reg_rdata_o <= {29'h0, irq_mask_r};
                default: reg_rdata_o <= 32'h0;
            endcase
        end
        else
            reg_rdata_o <= 32'h0;
    end

endmodule

/* File: tb/pll_ctrl_props.sv */
// Concurrent checks on the PLL controller ports
module pll_ctrl_props #(
    parameter int LOCK_CYCLES = pll_ctrl_pkg::LOCK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reference_clock_selector_o,
    input wire logic [1:0] step_output_o,
    input wire logic step_advance_o,
    input wire logic step_pulse_o,
    input wire logic [31:0] divider_cfg_o,
    input wire logic lock_valid_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ========================================
    // Helpers
    // Cycles spent unlocked; a relock must not come before the lock time
    int low_r;
    logic ctrl_wr;
    assign ctrl_wr = reg_wr_i && reg_addr_i == pll_ctrl_pkg::REG_CTRL;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            low_r <= 0;
        else if (lock_valid_o)
            low_r <= 0;
        else
            low_r <= low_r + 1;
    end
    sequence div_wr;
        reg_wr_i && reg_addr_i == pll_ctrl_pkg::REG_DIVIDERS;
    endsequence
    // ========================================
    // Assertions
    a_div_value: assert property (div_wr |-> ##2 divider_cfg_o == $past(reg_wdata_i, 2))
        else $error("divider copy wrong");
    a_div_unlock: assert property (div_wr |-> ##[1:3] !lock_valid_o)
        else $error("lock kept after settings write");
    a_step_unlock: assert property (step_pulse_o |-> ##[0:2] !lock_valid_o)
        else $error("lock kept after phase step");
    a_relock_wait: assert property ($rose(lock_valid_o) |-> low_r >= LOCK_CYCLES)
        else $error("relock too early");
    a_pulse_single: assert property (step_pulse_o |=> !step_pulse_o)
        else $error("step pulse too long");
    a_step_hold: assert property (
        !step_pulse_o |-> $stable(step_output_o) && $stable(step_advance_o))
        else $error("step outputs moved without a step");
    a_refsel_cause: assert property (
        !$stable(reference_clock_selector_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("reference select moved without write");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside answer cycle");
endmodule

bind pll_dynamic_phase_and_config_control pll_ctrl_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
    .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reference_clock_selector_o, .step_output_o, .step_advance_o, .step_pulse_o,
    .divider_cfg_o, .lock_valid_o
);

/* File: tb/pll_phase_driver.sv */
// User logic model driving the dynamic phase pins
module pll_phase_driver (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [1:0] sel_i,
    input wire logic dir_i,
    input wire logic [1:0] gap_i,
    output logic [1:0] phase_output_select_o,
    output logic phase_shift_direction_o,
    output logic phase_step_toggle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Select and direction settle first, so the synchroniser never splits them
    always @(posedge clk_i)
    begin
        if (go_i)
        begin
            phase_output_select_o <= sel_i;
            phase_shift_direction_o <= dir_i;
            repeat (3 + gap_i) @(posedge clk_i);
            phase_step_toggle_o <= ~phase_step_toggle_o;
        end
    end
    initial
    begin
        phase_output_select_o = 2'h0;
        phase_shift_direction_o = 1'b0;
        phase_step_toggle_o = 1'b0;
    end
endmodule

/* File: tb/pll_dynamic_phase_and_config_control_tb.sv */
// Self-checking bench for the PLL phase and settings controller
module pll_dynamic_phase_and_config_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LK = 8;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic go = 1'b0;
    logic [1:0] psel = 2'h0;
    logic pdir = 1'b0;
    logic [1:0] gap = 2'h0;
    logic [31:0] reg_rdata_o, divider_cfg_o;
    logic [1:0] phase_output_select_i, step_output_o;
    logic phase_shift_direction_i, phase_step_toggle_i, reference_clock_selector_o;
    logic step_advance_o, step_pulse_o, lock_valid_o, irq_o;
    int failures = 0;
    int n_compared = 0;
    // Bench model of the register state
    int ctrl_m = 0;
    int irq_m = 0;
    int mask_m = 0;
    int dir_m = 0;
    int div_m;
    // Clock at 100 MHz
    always #5 sys_clk_i = ~sys_clk_i;
    pll_dynamic_phase_and_config_control #(.LOCK_CYCLES(LK)) DUT (
        .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .phase_output_select_i, .phase_shift_direction_i, .phase_step_toggle_i,
        .reference_clock_selector_o, .step_output_o, .step_advance_o, .step_pulse_o,
        .divider_cfg_o, .lock_valid_o, .irq_o
    );
    pll_phase_driver u_drv (
        .clk_i(sys_clk_i), .go_i(go), .sel_i(psel), .dir_i(pdir), .gap_i(gap),
        .phase_output_select_o(phase_output_select_i),
        .phase_shift_direction_o(phase_shift_direction_i),
        .phase_step_toggle_o(phase_step_toggle_i)
    );
    // ========================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Register port stands in for the hardened function block bus path
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        if (a == pll_ctrl_pkg::REG_CTRL)
            ctrl_m = d & 32'hfb;
        if (a == pll_ctrl_pkg::REG_DIVIDERS)
            irq_m |= 2;
        if (a == pll_ctrl_pkg::REG_IRQ_MASK)
            mask_m = d;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(what, exp, reg_rdata_o);
        if (a == pll_ctrl_pkg::REG_IRQ_STATUS)
            irq_m = 0;
    endtask
    // Relock is bounded; running out of the bound ends the run
    task automatic wait_lock();
        int n;
        n = 0;
        while (lock_valid_o !== 1'b1 && n < 40)
        begin
            hold(1);
            n++;
        end
        if (n == 40)
        begin
            failures++;
            give_verdict();
        end
        else
            chk("lock_wait", 1, n >= LK - 3);
        irq_m |= 4;
    endtask
    task automatic step(input int s, input int d, input int en);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        go <= 1'b1;
        psel <= s[1:0];
        pdir <= d[0];
        gap <= 2'($urandom_range(0, 3));
        @(posedge sys_clk_i);
        go <= 1'b0;
        while (step_pulse_o !== 1'b1 && n < 16)
        begin
            hold(1);
            n++;
        end
        chk("step_pulse", en, n < 16);
        if (en != 0)
        begin
            chk("step_output", s, step_output_o);
            chk("step_advance", d, step_advance_o);
            chk("lock_step", 0, lock_valid_o);
            dir_m = d;
            irq_m |= 1;
        end
    endtask
    // ========================================
    // Main sequence
    initial
    begin
        void'($urandom(56957));
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        chk("div_rst", pll_ctrl_pkg::DIVIDERS_RST, divider_cfg_o);
        wait_lock();
        wr(pll_ctrl_pkg::REG_CTRL, 32'h3);
        hold(2);
        chk("refsel", ctrl_m & 1, reference_clock_selector_o);
        rd(pll_ctrl_pkg::REG_CTRL, ctrl_m, "ctrl");
        for (int i = 0; i < 8; i++)
            step(i / 2, i % 2, 1);
        // Software step: dynamic on, step, advance, select 2
        wr(pll_ctrl_pkg::REG_CTRL, 32'h2e);
        hold(1);
        chk("sw_step_pulse", 1, step_pulse_o);
        chk("sw_step_output", 2, step_output_o);
        chk("sw_step_advance", 1, step_advance_o);
        chk("sw_step_lock", 0, lock_valid_o);
        dir_m = 1;
        rd(pll_ctrl_pkg::REG_CTRL, ctrl_m, "ctrl_selfclear");
        wait_lock();
        wr(pll_ctrl_pkg::REG_CTRL, 32'h1);
        step(2, 0, 0);
        div_m = $urandom();
        wr(pll_ctrl_pkg::REG_DIVIDERS, div_m);
        hold(2);
        chk("div_cfg", div_m, divider_cfg_o);
        chk("lock_cfg", 0, lock_valid_o);
        wait_lock();
        rd(pll_ctrl_pkg::REG_DIVIDERS, div_m, "div_read");
        wr(pll_ctrl_pkg::REG_PHASE_CFG, div_m);
        rd(pll_ctrl_pkg::REG_PHASE_CFG, div_m & 32'hffff, "phase_cfg");
        wr(pll_ctrl_pkg::REG_STATUS, 32'hffff_ffff);
        rd(pll_ctrl_pkg::REG_STATUS, dir_m * 4 + 2 + (ctrl_m & 1), "status");
        rd(4'hf, 0, "unmapped");
        chk("irq_masked", 0, irq_o);
        wr(pll_ctrl_pkg::REG_IRQ_MASK, 32'h1);
        hold(1);
        chk("irq_set", (irq_m & mask_m) != 0, irq_o);
        rd(pll_ctrl_pkg::REG_IRQ_STATUS, irq_m, "irq_status");
        hold(1);
        chk("irq_clear", 0, irq_o);
        give_verdict();
    end
endmodule
